// ==== rtl/vse_top.sv ====
// vertical sync extractor: slicer, integrator, latch, oscillator
`timescale 1ns/1ps
`include "vse_consts.svh"
module vse_top
    import vse_pkg::*;
#(
    parameter int SW = `VSE_SAMPLE_WIDTH,
    parameter int IW = `VSE_INT_WIDTH,
    parameter int OW = `VSE_OSC_WIDTH,
    parameter logic [SW-1:0] SLICE_OFFSET = SW'(`VSE_SLICE_OFFSET_MV)
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [SW-1:0] video_i,
    input wire logic [SW-1:0] tip_level_i,
    input wire logic [IW-1:0] sample_div_i,
    input wire logic [IW-1:0] charge_step_i,
    input wire logic [IW-1:0] serration_level_threshold_i,
    input wire logic [IW-1:0] default_level_threshold_i,
    input wire logic [OW-1:0] osc_half_period_i,
    output logic comp_sync_n_o,
    output logic vert_sync_n_o,
    output logic field_clock_o
);
    // ======================================================
    // state
    typedef struct packed {
        logic [SW-1:0] vid_m;
        logic [SW-1:0] vid_s;
        logic sync;
        logic sync_prev;
        logic [IW-1:0] tick_cnt;
        logic [IW-1:0] integ;
        logic ser_sample;
        vse_state_t state;
        logic [OW-1:0] osc_cnt;
        logic osc;
        logic [`VSE_DIV_WIDTH-1:0] div;
        logic comp_n;
        logic vert_n;
        logic field_clk;
    } vse_st_t;

    vse_st_t st_q;
    vse_st_t st_d;

    logic tick;
    logic ser_hi;
    logic def_hi;
    logic ser_fall;
    logic set_latch;
    logic osc_fall;

    // threshold compare, used for both comparators
    function automatic logic above(input logic [IW-1:0] lvl,
                                   input logic [IW-1:0] thr);
        above = (lvl >= thr);
    endfunction : above

    // ======================================================
    // next state
    always_comb begin
        st_d = st_q;
        // two flops on the asynchronous video samples
        st_d.vid_m = video_i;
        st_d.vid_s = st_q.vid_m;
        // slicing level is a fixed offset over the tip
        st_d.sync = (st_q.vid_s < tip_level_i + SLICE_OFFSET);
        st_d.sync_prev = st_q.sync;
        st_d.comp_n = ~st_q.sync;
        tick = (st_q.tick_cnt >= sample_div_i);
        st_d.tick_cnt = tick ? '0 : st_q.tick_cnt + IW'(1);
        // integrator: ramps on internal sync, clears outside it
        // so short horizontal pulses never reach the threshold
        if (!st_q.sync) begin
            st_d.integ = '0;
        end else if (tick && st_q.integ < {IW{1'b1}} - charge_step_i) begin
            st_d.integ = st_q.integ + charge_step_i;
        end
        ser_hi = above(st_q.integ, serration_level_threshold_i);
        def_hi = above(st_q.integ, default_level_threshold_i);
        // end of a sync-low interval: serration or trailing edge
        ser_fall = st_q.sync_prev && !st_q.sync;
        if (ser_fall) begin
            st_d.ser_sample = ser_hi;
        end else begin
            st_d.ser_sample = 1'b0;
        end
        set_latch = st_q.ser_sample || def_hi;
        osc_fall = 1'b0;
        case (st_q.state)
            VSE_IDLE: begin
                st_d.osc_cnt = '0;
                st_d.osc = 1'b0;
                st_d.div = '0;
                if (set_latch) begin
                    st_d.state = VSE_PULSE;
                end
            end
            VSE_PULSE: begin
                // oscillator gated by latch; period set by osc_half_period_i alone
                if (st_q.osc_cnt >= osc_half_period_i) begin
                    st_d.osc_cnt = '0;
                    st_d.osc = ~st_q.osc;
                    osc_fall = st_q.osc;
                end else begin
                    st_d.osc_cnt = st_q.osc_cnt + OW'(1);
                end
                if (osc_fall) begin
                    st_d.div = st_q.div + 3'h1;
                    if (st_q.div == 3'(`VSE_OSC_CYCLES - 1)) begin
                        st_d.state = VSE_IDLE;
                    end
                end
            end
            default: st_d.state = VSE_IDLE;
        endcase
        st_d.vert_n = (st_d.state != VSE_PULSE);
        st_d.field_clk = (st_d.state == VSE_PULSE);
    end

    // ======================================================
    // registers
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            st_q <= '0;
            // video idles high; a zero here would fake a sync pulse
            st_q.vid_m <= '1;
            st_q.vid_s <= '1;
            st_q.state <= VSE_IDLE;
            st_q.comp_n <= 1'b1;
            st_q.vert_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign comp_sync_n_o = st_q.comp_n;
    assign vert_sync_n_o = st_q.vert_n;
    assign field_clock_o = st_q.field_clk;

    // ======================================================
    // checks
    a_slice_follow: assert property (@(posedge clock_i)
        disable iff (!reset_n_i) $fell(st_q.sync) |=> comp_sync_n_o)
        else $error("comp sync not released after sync end");
    a_integ_clear: assert property (@(posedge clock_i)
        disable iff (!reset_n_i) !st_q.sync |=> st_q.integ == '0)
        else $error("integrator not cleared outside sync");
    a_sample_set: assert property (@(posedge clock_i)
        disable iff (!reset_n_i) ser_fall && ser_hi |=> st_q.ser_sample)
        else $error("serration sample missed");
    a_latch_set: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        st_q.state == VSE_IDLE && set_latch |=> st_q.state == VSE_PULSE)
        else $error("latch not set");
    a_vert_low: assert property (@(posedge clock_i)
        disable iff (!reset_n_i) vert_sync_n_o == (st_q.state != VSE_PULSE))
        else $error("vertical output not latch complement");
    a_field_clk: assert property (@(posedge clock_i)
        disable iff (!reset_n_i) field_clock_o == !vert_sync_n_o)
        else $error("field clock not latch state");
    a_div_end: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        osc_fall && st_q.div == 3'h7 |=> st_q.state == VSE_IDLE)
        else $error("latch not reset after eight cycles");
    a_default_set: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        st_q.state == VSE_IDLE && def_hi |=> ##1 !vert_sync_n_o)
        else $error("default pulse missing");
    a_int_rise: assert property (@(posedge clock_i)
        disable iff (!reset_n_i)
        st_q.sync && st_d.sync && tick && !def_hi && st_q.integ < 16'h8000
        |=> st_q.integ > $past(st_q.integ))
        else $error("integrator not charging");
    c_vert_pulse: cover property (@(posedge clock_i) $fell(vert_sync_n_o));
    c_default: cover property (@(posedge clock_i)
        def_hi && st_q.state == VSE_IDLE);
    c_retrigger: cover property (@(posedge clock_i)
        $rose(vert_sync_n_o) ##[1:1000] $fell(vert_sync_n_o));
endmodule : vse_top

// ==== rtl/vse_consts.svh ====
// constants for the vertical sync extractor
// Behaviour
// - sync asserted while input below slice level
// - integrator charges only during inverted sync
// - one timing setting sets charge and oscillator; charge uses charge_step_i, oscillator osc_half_period_i
// - normal lines stay below serration threshold
// - broad pulse lifts integrator between thresholds
// - sample serration comparator at serration fall
// - sampled bit OR default comparator sets latch
// - latch enables oscillator and clocks field flop
// - divide-by-8 of oscillator resets the latch
// - vertical output is latch complement, active low
// - pulse starts at first qualifying serration edge
// - later qualifying edge retriggers, no lockout; code ignores set_latch while in VSE_PULSE until the 8 oscillator cycles end
// - default threshold starts pulse without serration
// - trailing sync edge retriggers after short default; code ignores that edge while in VSE_PULSE, as it ignores set_latch
`ifndef VSE_CONSTS_SVH
`define VSE_CONSTS_SVH
// ==========================================================
// slicer and timing defaults
`define VSE_SLICE_OFFSET_MV 70
`define VSE_SAMPLE_WIDTH 8
`define VSE_INT_WIDTH 16
`define VSE_OSC_WIDTH 16
`define VSE_OSC_CYCLES 8
`define VSE_DIV_WIDTH 3
`define VSE_SAMPLE_DIV 16'h0064
`define VSE_CHARGE_STEP 16'h0001
`define VSE_SER_THRESH 16'h0190
`define VSE_DEF_THRESH 16'h0320
`define VSE_OSC_PERIOD 16'h0960
`endif

// ==== rtl/vse_pkg.sv ====
// types for the vertical sync extractor
package vse_pkg;
    typedef enum logic {
        VSE_IDLE,
        VSE_PULSE
    } vse_state_t;
endpackage : vse_pkg

// ==== verification/vse_video_src.sv ====
// composite video source model: bursts of sync with random levels
`timescale 1ns/1ps
module vse_video_src (
    input wire logic clock_i,
    input wire logic start_i,
    input wire logic [7:0] tip_i,
    input wire logic [7:0] low_i,
    input wire logic [7:0] high_i,
    input wire logic [7:0] count_i,
    output logic [7:0] video_o,
    output logic busy_o
);
    int seed = 67;
    int ph = 0;
    int n = 0;
    logic go;
    initial begin
        video_o = 8'hFF;
        busy_o = 1'b0;
    end
    // ==========================================================
    // burst: low_i below slice then high_i above, count_i times
    // start is taken at the edge itself so the bench may drop it at +1
    always @(posedge clock_i) begin
        go = start_i;
        #1;
        if (go && !busy_o) begin
            busy_o = 1'b1;
            ph = 0;
            n = 0;
        end
        // broad pulse of 12 in 14 keeps above 85% of the half line
        if (busy_o && ph < int'(low_i)) begin
            video_o = tip_i + 8'($random(seed) & 63);
        end else begin
            video_o = tip_i + 8'h46 + 8'($random(seed) & 63);
        end
        if (busy_o) begin
            ph++;
            if (ph == int'(low_i) + int'(high_i)) begin
                ph = 0;
                n++;
            end
            // short bursts so eight periods cover them
            if (n == int'(count_i)) busy_o = 1'b0;
        end
    end
endmodule : vse_video_src

// ==== verification/vse_top_bench.sv ====
// self-checking bench for the vertical sync extractor
`timescale 1ns/1ps
module vse_top_bench;
    logic clock_i, reset_n_i, start, busy, comp_n, vert_n, field;
    logic [7:0] tip, low, high, cnt, video;
    logic [3:0][7:0] h = {4{8'hFF}};
    logic [15:0] q [$];
    logic [15:0] step = 16'h0001;
    int num_errors = 0;
    int checks = 0;
    int seed = 67;
    int w = 0;
    vse_top u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .video_i(video), .tip_level_i(tip), .sample_div_i(16'h0000),
        .charge_step_i(step), .serration_level_threshold_i(16'h0004),
        .default_level_threshold_i(16'h0010), .osc_half_period_i(16'h0002),
        .comp_sync_n_o(comp_n), .vert_sync_n_o(vert_n),
        .field_clock_o(field));
    vse_video_src u_src (.clock_i(clock_i), .start_i(start), .tip_i(tip),
        .low_i(low), .high_i(high), .count_i(cnt), .video_o(video),
        .busy_o(busy));
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        if (num_errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    // ==========================================================
    // one burst; expected 48-cycle pulses are noted first
    task automatic burst(input int lo, input int hi, input int n, int p);
        int t;
        t = 0;
        repeat (p) q.push_back(16'd48);
        @(posedge clock_i);
        #1;
        low = 8'(lo);
        high = 8'(hi);
        cnt = 8'(n);
        start = 1'b1;
        @(posedge clock_i);
        #1 start = 1'b0;
        do @(posedge clock_i); while (busy === 1'b1 && t++ < 5000);
        check("burst_done", 16'(busy), 16'd0);
        repeat (150) @(posedge clock_i);
    endtask : burst
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // ==========================================================
    // monitor: comp sync trails video by four edges
    // sampled on the falling edge so outputs have settled
    always @(negedge clock_i) if (reset_n_i) begin
        check("comp_sync", 16'(comp_n), 16'(h[3] >= tip + 8'h46));
        h <= {h[2:0], video};
        check("field_clock", 16'(field), 16'(!vert_n));
        if (!vert_n) w++;
        else if (w > 0) begin
            if (q.size() == 0) check("vert_extra", 16'(w), 16'd0);
            else check("vert_width", (w >= 47 && w <= 49) ? 16'd48
                : 16'(w), q.pop_front());
            w = 0;
        end
    end
    initial begin
        reset_n_i = 1'b0;
        start = 1'b0;
        {low, high, cnt} = 24'h0;
        tip = 8'($random(seed) & 63);
        repeat (20) @(posedge clock_i);
        check("vert_reset", 16'({vert_n, field}), 16'd2);
        #1 reset_n_i = 1'b1;
        burst(2, 20, 10, 0);
        burst(12, 2, 4, 1);
        burst(12, 2, 8, 2);
        burst(40, 20, 1, 1);
        burst(100, 20, 1, 2);
        check("pulses_left", 16'(q.size()), 16'd0);
        complete_run();
    end
    initial begin
        #100000;
        num_errors++;
        complete_run();
    end
endmodule : vse_top_bench
